// >>> hw/timer_cfg.svh
// Register indices, field positions, reset values and divider counts
// for the split auto-reload timer.
// Assumes a 32-bit APB slave: byte address is four times the index.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// =====================================================================
// Register indices (byte address = index * 4)
`define TMR_IDX_CLKCTRL 10'h08e
`define TMR_IDX_CONTROL 10'h091
`define TMR_IDX_RELOAD_LOW 10'h092
`define TMR_IDX_RELOAD_HIGH 10'h093
`define TMR_IDX_COUNT_LOW 10'h094
`define TMR_IDX_COUNT_HIGH 10'h095
`define TMR_IDX_CAPSTAT 10'h096
`define TMR_IDX_IRQEN 10'h0e6

// =====================================================================
// Control register fields
`define TMR_CTL_HIGH_FLAG 7
`define TMR_CTL_LOW_FLAG 6
`define TMR_CTL_LOW_IRQ_EN 5
`define TMR_CTL_CAP_EN 4
`define TMR_CTL_SPLIT 3
`define TMR_CTL_RUN 2
`define TMR_CTL_UNUSED 1
`define TMR_CTL_EXT_SEL 0

// =====================================================================
// Other fields
`define TMR_CLK_HIGH_SEL 7
`define TMR_CLK_LOW_SEL 6
`define TMR_IRQEN_BIT 7
`define TMR_CAPSTAT_FLAG 0

// =====================================================================
// Reset values and constants
`define TMR_RST_BYTE 8'h00
`define TMR_BYTE_ONES 8'hff
`define TMR_DIV_SYS 12
`define TMR_DIV_EXT 8

`endif

// >>> hw/timer_pkg.sv
// Types shared by the split auto-reload timer.
// Assumes timer_cfg.svh holds the numeric constants.
package timer_pkg;

  // =====================================================================
  // Shared types
  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    SRC_SYS,
    SRC_DIV12,
    SRC_EXT8
  } tick_src_t;

endpackage

// >>> hw/tick_gen.sv
// Count-source ticks: system clock / 12, external oscillator / 8,
// and rising edges of the low-frequency oscillator.
// Assumes ext_osc and lfo_out are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module tick_gen #(
  parameter int unsigned DIV_SYS = `TMR_DIV_SYS,
  parameter int unsigned DIV_EXT = `TMR_DIV_EXT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_osc,
  input wire logic lfo_out,
  output logic div12_tick,
  output logic ext8_tick,
  output logic lfo_rise
);

  // =====================================================================
  // Synchronisers for both asynchronous inputs
  logic [1:0] sync_in;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] last_q;
  logic [3:0] sys_cnt_q;
  logic [2:0] ext_cnt_q;
  logic ext_rise;

  assign sync_in = {lfo_out, ext_osc};

  // Two flops per input, then an edge history flop
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
        last_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= sync_in[i];
        sync_q[i] <= meta_q[i];
        last_q[i] <= sync_q[i];
      end
    end
  end

  assign ext_rise = sync_q[0] & ~last_q[0];
  assign lfo_rise = sync_q[1] & ~last_q[1];

  // System clock prescaler, one tick every DIV_SYS cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_cnt_q <= 4'h0;
    end else if (sys_cnt_q == 4'(DIV_SYS - 1)) begin
      sys_cnt_q <= 4'h0;
    end else begin
      sys_cnt_q <= sys_cnt_q + 4'h1;
    end
  end

  assign div12_tick = (sys_cnt_q == 4'(DIV_SYS - 1));

  // External prescaler, one tick every DIV_EXT synchronised edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_q <= 3'h0;
    end else if (ext_rise) begin
      ext_cnt_q <= (ext_cnt_q == 3'(DIV_EXT - 1)) ? 3'h0 : ext_cnt_q + 3'h1;
    end
  end

  assign ext8_tick = ext_rise & (ext_cnt_q == 3'(DIV_EXT - 1));

endmodule // tick_gen
`default_nettype wire

// >>> hw/auto_reload_timer_split.sv
// Split auto-reload timer: one 16-bit or two 8-bit counters with
// overflow flags, low-frequency oscillator capture and an irq request.
// Assumes an APB master on pclk; ext_osc and lfo_out are asynchronous.
//
// Summary of operation
// - 16-bit mode wraps at FFFF, loads reload pair, sets high flag.
// - Control bit 3 picks 16-bit mode at 0, split mode at 1.
// - 16-bit mode requests interrupt on every full overflow when enabled.
// - 16-bit mode with low enable also interrupts on low byte wrap.
// - Split mode reloads each byte from its own reload register.
// - Run bit gates whole timer, or only high byte in split mode.
// - Select 1 uses system clock; else div 12 or external div 8.
// - Each byte has its own select; one external select serves both.
// - External divide-by-eight source is synchronised before counting.
// - High flag, control bit 7, sets when high byte wraps.
// - Low flag, control bit 6, sets when low byte wraps, any mode.
// - Split mode interrupts on high wrap, plus low wrap when enabled.
// - Flags never clear by hardware; only a software write of zero.
// - Capture enable with interrupts: lfo rise copies count into reload.
// - Control bit 5 enables low byte overflow interrupts.
// - Control bit 0 selects div 12 at 0, external div 8 at 1.
// - Control bit 1 reads zero and ignores writes.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module auto_reload_timer_split #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DIV_SYS = `TMR_DIV_SYS,
  parameter int unsigned DIV_EXT = `TMR_DIV_EXT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_osc,
  input wire logic lfo_out,
  output logic irq_req
);

  // =====================================================================
  // State
  timer_pkg::byte_t count_low_byte_q;
  timer_pkg::byte_t count_high_byte_q;
  timer_pkg::byte_t reload_low_byte_q;
  timer_pkg::byte_t reload_high_byte_q;
  logic high_overflow_flag_q;
  logic low_overflow_flag_q;
  logic low_byte_irq_enable_q;
  logic lfo_capture_enable_q;
  logic split_mode_bit_q;
  logic run_bit_q;
  logic external_select_bit_q;
  logic high_clock_select_q;
  logic low_clock_select_q;
  logic timer_irq_enable_q;
  logic capture_flag_q;
  logic [31:0] prdata_q;

  // =====================================================================
  // Working signals
  logic [9:0] reg_idx;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_clk;
  logic hit_ctl;
  logic hit_rll;
  logic hit_rlh;
  logic hit_cnl;
  logic hit_cnh;
  logic hit_cap;
  logic hit_ien;
  logic mapped;
  timer_pkg::byte_t wbyte;
  timer_pkg::byte_t ctl_value;
  logic [31:0] rd_value;
  logic div12_tick;
  logic ext8_tick;
  logic lfo_rise;
  timer_pkg::tick_src_t low_src;
  timer_pkg::tick_src_t high_src;
  logic low_tick;
  logic high_tick;
  logic step_low;
  logic step_high;
  logic low_wrap;
  logic high_wrap;
  logic load_low;
  logic load_high;
  logic capture;

  // =====================================================================
  // Count-source ticks
  tick_gen #(
    .DIV_SYS(DIV_SYS),
    .DIV_EXT(DIV_EXT)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ext_osc(ext_osc),
    .lfo_out(lfo_out),
    .div12_tick(div12_tick),
    .ext8_tick(ext8_tick),
    .lfo_rise(lfo_rise)
  );

  // =====================================================================
  // APB decode
  assign reg_idx = 10'(paddr[ADDR_W-1:2]);
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wbyte = pwdata[7:0];

  // Address hits
  assign hit_clk = (reg_idx == `TMR_IDX_CLKCTRL);
  assign hit_ctl = (reg_idx == `TMR_IDX_CONTROL);
  assign hit_rll = (reg_idx == `TMR_IDX_RELOAD_LOW);
  assign hit_rlh = (reg_idx == `TMR_IDX_RELOAD_HIGH);
  assign hit_cnl = (reg_idx == `TMR_IDX_COUNT_LOW);
  assign hit_cnh = (reg_idx == `TMR_IDX_COUNT_HIGH);
  assign hit_cap = (reg_idx == `TMR_IDX_CAPSTAT);
  assign hit_ien = (reg_idx == `TMR_IDX_IRQEN);
  assign mapped = hit_clk | hit_ctl | hit_rll | hit_rlh | hit_cnl |
                  hit_cnh | hit_cap | hit_ien;

  // Writes land only at the access edge, low byte lane, mapped address
  assign wr_en = access_ph & pwrite & pstrb[0] & mapped;

  // Zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_q;

  // =====================================================================
  // Count-source selection per byte
  function automatic timer_pkg::tick_src_t pick_src(
    input logic fast_sel,
    input logic ext_sel
  );
    if (fast_sel) begin
      return timer_pkg::SRC_SYS;
    end else if (ext_sel) begin
      return timer_pkg::SRC_EXT8;
    end else begin
      return timer_pkg::SRC_DIV12;
    end
  endfunction

  function automatic logic src_tick(
    input timer_pkg::tick_src_t src,
    input logic t12,
    input logic t8
  );
    logic t;
    t = 1'b0;
    case (src)
      timer_pkg::SRC_SYS: t = 1'b1;
      timer_pkg::SRC_DIV12: t = t12;
      timer_pkg::SRC_EXT8: t = t8;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Own select per byte, shared external select
  assign low_src = pick_src(low_clock_select_q, external_select_bit_q);
  assign high_src = pick_src(high_clock_select_q, external_select_bit_q);
  assign low_tick = src_tick(low_src, div12_tick, ext8_tick);
  assign high_tick = src_tick(high_src, div12_tick, ext8_tick);

  // =====================================================================
  // Step, wrap and reload decisions
  // In 16-bit mode the low byte's source clocks the whole counter.
  always_comb begin
    if (split_mode_bit_q) begin
      step_low = low_tick;
      step_high = run_bit_q & high_tick;
    end else begin
      step_low = run_bit_q & low_tick;
      step_high = 1'b0;
    end
    low_wrap = step_low & (count_low_byte_q == `TMR_BYTE_ONES);
    if (!split_mode_bit_q) begin
      step_high = low_wrap;
    end
    high_wrap = step_high & (count_high_byte_q == `TMR_BYTE_ONES);
    load_low = split_mode_bit_q ? low_wrap : high_wrap;
    load_high = high_wrap;
  end

  // Capture needs both its enable and the timer interrupt enable
  assign capture = lfo_rise & lfo_capture_enable_q & timer_irq_enable_q;

  // =====================================================================
  // Low count byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_byte_q <= `TMR_RST_BYTE;
    end else if (wr_en & hit_cnl) begin
      count_low_byte_q <= wbyte;
    end else if (load_low) begin
      count_low_byte_q <= reload_low_byte_q;
    end else if (step_low) begin
      count_low_byte_q <= count_low_byte_q + 8'h01;
    end
  end

  // High count byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_high_byte_q <= `TMR_RST_BYTE;
    end else if (wr_en & hit_cnh) begin
      count_high_byte_q <= wbyte;
    end else if (load_high) begin
      count_high_byte_q <= reload_high_byte_q;
    end else if (step_high) begin
      count_high_byte_q <= count_high_byte_q + 8'h01;
    end
  end

  // =====================================================================
  // Reload bytes; a capture overrides a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_low_byte_q <= `TMR_RST_BYTE;
      reload_high_byte_q <= `TMR_RST_BYTE;
    end else if (capture) begin
      reload_low_byte_q <= count_low_byte_q;
      reload_high_byte_q <= count_high_byte_q;
    end else if (wr_en) begin
      if (hit_rll) begin
        reload_low_byte_q <= wbyte;
      end
      if (hit_rlh) begin
        reload_high_byte_q <= wbyte;
      end
    end
  end

  // =====================================================================
  // Overflow flags; hardware set wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_overflow_flag_q <= 1'b0;
      low_overflow_flag_q <= 1'b0;
    end else begin
      if (high_wrap) begin
        high_overflow_flag_q <= 1'b1;
      end else if (wr_en & hit_ctl) begin
        high_overflow_flag_q <= wbyte[`TMR_CTL_HIGH_FLAG];
      end
      if (low_wrap) begin
        low_overflow_flag_q <= 1'b1;
      end else if (wr_en & hit_ctl) begin
        low_overflow_flag_q <= wbyte[`TMR_CTL_LOW_FLAG];
      end
    end
  end

  // Capture event flag, cleared by writing zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_flag_q <= 1'b0;
    end else if (capture) begin
      capture_flag_q <= 1'b1;
    end else if (wr_en & hit_cap) begin
      capture_flag_q <= wbyte[`TMR_CAPSTAT_FLAG];
    end
  end

  // =====================================================================
  // Control bits (bit 1 is not stored)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_irq_enable_q <= 1'b0;
      lfo_capture_enable_q <= 1'b0;
      split_mode_bit_q <= 1'b0;
      run_bit_q <= 1'b0;
      external_select_bit_q <= 1'b0;
    end else if (wr_en & hit_ctl) begin
      low_byte_irq_enable_q <= wbyte[`TMR_CTL_LOW_IRQ_EN];
      lfo_capture_enable_q <= wbyte[`TMR_CTL_CAP_EN];
      split_mode_bit_q <= wbyte[`TMR_CTL_SPLIT];
      run_bit_q <= wbyte[`TMR_CTL_RUN];
      external_select_bit_q <= wbyte[`TMR_CTL_EXT_SEL];
    end
  end

  // Clock selects and timer interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_clock_select_q <= 1'b0;
      low_clock_select_q <= 1'b0;
      timer_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      if (hit_clk) begin
        high_clock_select_q <= wbyte[`TMR_CLK_HIGH_SEL];
        low_clock_select_q <= wbyte[`TMR_CLK_LOW_SEL];
      end
      if (hit_ien) begin
        timer_irq_enable_q <= wbyte[`TMR_IRQEN_BIT];
      end
    end
  end

  // =====================================================================
  // Interrupt request, level while any enabled condition is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= timer_irq_enable_q &
                 (high_overflow_flag_q |
                  (low_byte_irq_enable_q & low_overflow_flag_q) |
                  capture_flag_q);
    end
  end

  // =====================================================================
  // Read path
  always_comb begin
    ctl_value = 8'h00;
    ctl_value[`TMR_CTL_HIGH_FLAG] = high_overflow_flag_q;
    ctl_value[`TMR_CTL_LOW_FLAG] = low_overflow_flag_q;
    ctl_value[`TMR_CTL_LOW_IRQ_EN] = low_byte_irq_enable_q;
    ctl_value[`TMR_CTL_CAP_EN] = lfo_capture_enable_q;
    ctl_value[`TMR_CTL_SPLIT] = split_mode_bit_q;
    ctl_value[`TMR_CTL_RUN] = run_bit_q;
    ctl_value[`TMR_CTL_UNUSED] = 1'b0;
    ctl_value[`TMR_CTL_EXT_SEL] = external_select_bit_q;
  end

  // Register select, upper bits read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit_ctl) begin
      rd_value[7:0] = ctl_value;
    end else if (hit_rll) begin
      rd_value[7:0] = reload_low_byte_q;
    end else if (hit_rlh) begin
      rd_value[7:0] = reload_high_byte_q;
    end else if (hit_cnl) begin
      rd_value[7:0] = count_low_byte_q;
    end else if (hit_cnh) begin
      rd_value[7:0] = count_high_byte_q;
    end else if (hit_clk) begin
      rd_value[`TMR_CLK_HIGH_SEL] = high_clock_select_q;
      rd_value[`TMR_CLK_LOW_SEL] = low_clock_select_q;
    end else if (hit_cap) begin
      rd_value[`TMR_CAPSTAT_FLAG] = capture_flag_q;
    end else if (hit_ien) begin
      rd_value[`TMR_IRQEN_BIT] = timer_irq_enable_q;
    end
  end

  // Read data sampled in the setup phase, held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      prdata_q <= rd_value;
    end
  end

endmodule // auto_reload_timer_split
`default_nettype wire

// >>> sim/auto_reload_timer_split_props.sv
// Checker for the split auto-reload timer: APB answers and irq masking.
// Assumes it is bound to auto_reload_timer_split and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module auto_reload_timer_split_props #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_osc,
  input wire logic lfo_out,
  input wire logic irq_req
);
  // =====================================================================
  // Helper state
  logic [ADDR_W-3:0] idx;
  logic rd_acc;
  logic wr_acc;
  logic mapped;
  logic [1:0] seen_q;
  logic en_q;
  logic [1:0] off_q;

  // Decoded access phase
  assign idx = paddr[ADDR_W-1:2];
  assign rd_acc = psel && penable && !pwrite;
  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign mapped = idx inside {`TMR_IDX_CLKCTRL, `TMR_IDX_IRQEN,
    [`TMR_IDX_CONTROL:`TMR_IDX_CAPSTAT]};

  // Flags last seen set, minus those written to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_q <= 2'h0;
    else if (rd_acc && idx == `TMR_IDX_CONTROL) seen_q <= prdata[7:6];
    else if (wr_acc && idx == `TMR_IDX_CONTROL) seen_q <= seen_q & pwdata[7:6];
  end

  // Shadow of the timer interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 1'b0;
    else if (wr_acc && idx == `TMR_IDX_IRQEN) en_q <= pwdata[`TMR_IRQEN_BIT];
  end

  // Cycles since the enable went off, saturating at two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_q <= 2'h2;
    else if (en_q) off_q <= 2'h0;
    else if (off_q != 2'h2) off_q <= off_q + 2'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =====================================================================
  // Properties
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  a_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unused_zero: assert property (
    rd_acc && idx == `TMR_IDX_CONTROL |-> !prdata[`TMR_CTL_UNUSED])
    else $error("unused control bit reads one");
  a_flag_sticky: assert property (
    rd_acc && idx == `TMR_IDX_CONTROL |-> (prdata[7:6] & seen_q) == seen_q)
    else $error("overflow flag cleared by hardware");
  a_rdata_stands: assert property (
    !$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("read data changed without read");
  a_irq_masked: assert property (off_q == 2'h2 |-> !irq_req)
    else $error("irq with interrupt disabled");
endmodule // auto_reload_timer_split_props

bind auto_reload_timer_split auto_reload_timer_split_props #(
  .ADDR_W(ADDR_W)
) i_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .ext_osc(ext_osc),
  .lfo_out(lfo_out),
  .irq_req(irq_req)
);
`default_nettype wire

// >>> sim/auto_reload_timer_split_tb.sv
// Self-checking bench for the split auto-reload timer.
// Assumes the design answers APB with zero wait states on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module auto_reload_timer_split_tb;
  localparam logic [9:0] ctl_i = `TMR_IDX_CONTROL;
  localparam logic [9:0] rll_i = `TMR_IDX_RELOAD_LOW;
  localparam logic [9:0] rlh_i = `TMR_IDX_RELOAD_HIGH;
  localparam logic [9:0] cnl_i = `TMR_IDX_COUNT_LOW;
  localparam logic [9:0] cnh_i = `TMR_IDX_COUNT_HIGH;
  localparam logic [9:0] sel_i = `TMR_IDX_CLKCTRL;
  localparam logic [9:0] cap_i = `TMR_IDX_CAPSTAT;
  localparam logic [9:0] ien_i = `TMR_IDX_IRQEN;
  logic [9:0] idxs [8] = '{ctl_i, rll_i, rlh_i, cnl_i, cnh_i, sel_i, cap_i,
    ien_i};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic ext_osc = 1'b0;
  logic lfo_out = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_req;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h367f;
  logic [31:0] rd;
  logic err;
  logic [7:0] r;
  logic [7:0] rl;
  logic [7:0] rh;
  int n;

  // Clock
  always #20 pclk = ~pclk;

  auto_reload_timer_split i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_osc(ext_osc), .lfo_out(lfo_out), .irq_req(irq_req));

  // =====================================================================
  // Helpers
  function automatic void rnd(output logic [7:0] v);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    v = seed[7:0];
  endfunction

  // Control readback: bit 1 always reads zero
  function automatic logic [7:0] exp_ctl(input logic [7:0] w);
    return w & 8'hfd;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d,
    input logic [3:0] sb);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= sb;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, i, d, 4'h1);
  endtask

  task automatic rdchk(input logic [9:0] i, input logic [7:0] e, string nm);
    apb(1'b0, i, 8'h00, 4'h0);
    chk(nm, {24'h0, e}, rd);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge pclk);
    chk("irq_req", {31'h0, e}, {31'h0, irq_req});
    @(posedge pclk);
  endtask

  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(40 * 30000);
    num_errors++;
    summarize();
  end

  // =====================================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped refusal
    foreach (idxs[i]) rdchk(idxs[i], 8'h00, "reset value");
    apb(1'b0, 10'h0a0, 8'h00, 4'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Control fields and the unused bit
    repeat (4) begin
      rnd(r);
      wr(ctl_i, (r & 8'h3b) | 8'h02);
      rdchk(ctl_i, exp_ctl((r & 8'h3b) | 8'h02), "control");
    end
    // Flags set by software with the interrupt disabled
    wr(ctl_i, 8'he0);
    irq_chk(1'b0);
    wr(ctl_i, 8'h00);
    apb(1'b1, rll_i, 8'h5a, 4'h0);
    rdchk(rll_i, 8'h00, "strobe off");
    // 16-bit wrap on divide-by-12 ticks
    rnd(rl);
    rl = rl & 8'h7f;
    rnd(rh);
    wr(rll_i, rl);
    wr(rlh_i, rh);
    rdchk(rlh_i, rh, "reload high");
    wr(cnl_i, 8'hff);
    wr(cnh_i, 8'hff);
    wr(ien_i, 8'h80);
    wr(ctl_i, 8'h24);
    n = 0;
    do begin
      apb(1'b0, ctl_i, 8'h00, 4'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 20);
    chk("flags on wrap", 32'h0000_00e4, rd);
    wr(ctl_i, 8'he0);
    rdchk(ctl_i, 8'he0, "both flags");
    irq_chk(1'b1);
    rdchk(cnh_i, rh, "reloaded high");
    rdchk(cnl_i, rl, "reloaded low");
    repeat (30) @(posedge pclk);
    rdchk(cnl_i, rl, "stopped count");
    rdchk(ctl_i, 8'he0, "flags kept");
    wr(ctl_i, 8'h20);
    irq_chk(1'b0);
    // Split: low runs alone on system clock, reloads from its register
    rnd(r);
    wr(sel_i, 8'h40);
    wr(cnh_i, r);
    wr(rll_i, 8'hfe);
    wr(ctl_i, 8'h08);
    repeat (300) @(posedge pclk);
    rdchk(ctl_i, 8'h48, "split flags");
    rdchk(cnh_i, r, "high held");
    apb(1'b0, cnl_i, 8'h00, 4'h0);
    chk("split reload", (rd == 32'hff) ? 32'hff : 32'hfe, rd);
    irq_chk(1'b0);
    wr(ctl_i, 8'h68);
    irq_chk(1'b1);
    // Split: high runs on system clock, low slow on divide-by-12
    wr(sel_i, 8'h80);
    wr(cnl_i, 8'h00);
    wr(cnh_i, 8'hf0);
    wr(rlh_i, 8'h33);
    wr(ctl_i, 8'h0c);
    repeat (40) @(posedge pclk);
    rdchk(ctl_i, 8'h8c, "split high wrap");
    irq_chk(1'b1);
    wr(ctl_i, 8'h00);
    wr(sel_i, 8'h00);
    // External divide-by-8 source
    wr(cnl_i, 8'hff);
    wr(cnh_i, 8'hff);
    wr(ctl_i, 8'h05);
    repeat (40) @(posedge pclk);
    rdchk(ctl_i, 8'h05, "no ext edges");
    repeat (8) begin
      rnd(r);
      repeat (2 + r[1:0]) @(posedge pclk);
      ext_osc <= 1'b1;
      repeat (2 + r[3:2]) @(posedge pclk);
      ext_osc <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    rdchk(ctl_i, 8'hc5, "ext wrap");
    wr(ctl_i, 8'h00);
    // Low-frequency capture
    rnd(rl);
    rnd(rh);
    wr(cnl_i, rl);
    wr(cnh_i, rh);
    wr(ctl_i, 8'h10);
    lfo_out <= 1'b1;
    repeat (8) @(posedge pclk);
    lfo_out <= 1'b0;
    rdchk(rll_i, rl, "capture low");
    rdchk(rlh_i, rh, "capture high");
    irq_chk(1'b1);
    rdchk(cap_i, 8'h01, "capture flag");
    wr(cap_i, 8'h00);
    irq_chk(1'b0);
    summarize();
  end
endmodule // auto_reload_timer_split_tb
`default_nettype wire
